// ### src/ssc_consts.vh
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// ============================================================
// Line word layout of an SPI-4.2 control word.
`define SSC_WORD_W          16
`define SSC_CW_TYPE_BIT     15
`define SSC_CW_EOPS_HI      14
`define SSC_CW_EOPS_LO      13
`define SSC_CW_SOP_BIT      12
`define SSC_CW_ADDR_HI      11
`define SSC_CW_ADDR_LO      4
`define SSC_CW_DIP_HI       3
`define SSC_CW_DIP_LO       0
`define SSC_DIP_FILL        4'hF

// ============================================================
// Training pattern and its reporting length.
`define SSC_TRAIN_CTRL_WORD 16'h0FFF
`define SSC_TRAIN_DATA_WORD 16'hF000
`define SSC_TRAIN_REPS      4'hA
`define SSC_TRAIN_HOLD      5'h14

// ============================================================
// Framing, spacing and synchronisation counts.
`define SSC_FRAMING_STATUS  2'h3
`define SSC_MIN_SOP_SPACING 4'h8
`define SSC_LOSS_COUNT      3'h4
`define SSC_GAIN_COUNT      3'h4

// ============================================================
// Fault cause bit positions.
`define SSC_CAUSE_SOP_SPACE 0
`define SSC_CAUSE_EOP_NODAT 1
`define SSC_CAUSE_PAY_NODAT 2
`define SSC_CAUSE_DIP4      3
`define SSC_CAUSE_RSVD_CW   4
`define SSC_CAUSE_ADDR_NZ   5
`define SSC_CAUSE_W         8

`endif

// ### src/ssc_ddr_capture.v
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"

// ============================================================
// Double edge capture of the line bus against the sampled line clock.
module ssc_ddr_capture (
  input  wire                    core_clk,
  input  wire                    rst_b,
  input  wire                    line_clk,
  input  wire [`SSC_WORD_W-1:0]  line_bus,
  input  wire                    line_ctrl,
  output wire                    line_rise,
  output reg                     word_strobe,
  output reg  [`SSC_WORD_W-1:0]  word,
  output reg                     word_ctrl
);

  // Previous line clock sample; left out of reset so the status divider keeps running.
  reg line_clk_q = 1'b0;

  // The line clock is a free running source clock, so its edges are seen during reset too.
  always @(posedge core_clk) begin
    line_clk_q <= line_clk;
  end

  // A rising line clock edge steps the status clock divider.
  assign line_rise = line_clk & ~line_clk_q;

  // Every change of the line clock, rising or falling, takes one bus word.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      word_strobe <= 1'b0;
      word        <= 16'h0000;
      word_ctrl   <= 1'b0;
    end else begin
      word_strobe <= line_clk ^ line_clk_q;
      if (line_clk ^ line_clk_q) begin
        word      <= line_bus;
        word_ctrl <= line_ctrl;
      end
    end
  end

endmodule

`default_nettype wire

// ### src/ssc_status_tx.v
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"

// ============================================================
// Status clock divider and two bit status output.
module ssc_status_tx (
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire       line_rise,
  input  wire       div_eighth,
  input  wire       force_framing,
  input  wire [1:0] status_in,
  output reg        status_clk,
  output reg  [1:0] status_bits
);

  // Divider state is power-up initialised and not reset, so the clock never stops.
  reg  [1:0] div_cnt = 2'h0;
  // Toggle point: every second rise for a quarter rate, every fourth for an eighth.
  wire       div_hit;
  // A falling status clock edge, used to launch the next status pair.
  wire       fall_now;

  assign div_hit  = line_rise & (div_eighth ? (div_cnt == 2'h3) : div_cnt[0]);
  assign fall_now = div_hit & status_clk;

  // Divider runs regardless of reset or enable.
  always @(posedge core_clk) begin
    if (line_rise) begin
      div_cnt <= div_cnt + 2'h1;
    end
    if (div_hit) begin
      status_clk <= ~status_clk;
    end
  end

  initial status_clk = 1'b0;

  // Status pairs change on the falling edge so the peer samples them on the rising edge.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      status_bits <= `SSC_FRAMING_STATUS;
    end else if (force_framing) begin
      status_bits <= `SSC_FRAMING_STATUS;
    end else if (fall_now) begin
      status_bits <= status_in;
    end
  end

endmodule

`default_nettype wire

// ### src/ssc_sink_control_status.v
// Function
// - Sample bus on both line clock edges.
// - Line bus is sixteen bits wide.
// - Control flag high marks a control word.
// - Reset clears all but line clock sample and status divider.
// - Reset: out of frame, path cleared.
// - Reset: send framing and keep status clock.
// - Flush clears buffer path, keeps frame.
// - After flush, drop words until SOP.
// - Disabled: out of frame, stop storing.
// - Disabled: flags low, framing, clock running.
// - Out of sync when disabled or lost.
// - Out of sync drops when regained.
// - Fault pulse for packet-less protocol errors.
// - Eight bit cause vector with fault.
// - Causes: SOP spacing, bare EOP, bare payload.
// - Causes: DIP4, reserved word, nonzero address.
// - Top two cause bits held low.
// - Training flag held for twenty words.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"

// ============================================================
// Receive sink line interface with control and status logic.
module ssc_sink_control_status #(
  parameter [3:0] MIN_SOP_SPACING = `SSC_MIN_SOP_SPACING,
  parameter [2:0] LOSS_COUNT      = `SSC_LOSS_COUNT,
  parameter [2:0] GAIN_COUNT      = `SSC_GAIN_COUNT
) (
  input  wire                    core_clk,
  input  wire                    rst_b,
  input  wire                    rx_line_clock,
  input  wire [`SSC_WORD_W-1:0]  rx_line_bus,
  input  wire                    rx_line_ctrl_flag,
  input  wire                    flow_status_clock_divider,
  input  wire [1:0]              flow_status_word,
  input  wire                    buffer_flush_low,
  input  wire                    receiver_enable,
  output wire                    rx_flow_status_clock,
  output wire [1:0]              rx_flow_status_bits,
  output reg                     receiver_out_of_sync,
  output reg                     receiver_protocol_fault,
  output reg  [`SSC_CAUSE_W-1:0] receiver_fault_cause,
  output reg                     training_seen,
  output reg                     buffer_clear,
  output reg                     store_valid,
  output reg  [`SSC_WORD_W-1:0]  store_word,
  output reg                     store_ctrl
);

  // ============================================================
  // Declarations.

  // Captured word stream.
  wire                   ws;
  wire [`SSC_WORD_W-1:0] w;
  wire                   w_ctrl;
  // Rising edge of the line clock for the status divider.
  wire                   line_rise;

  // Enable synchroniser, first and second stage.
  reg                    en_meta;
  reg                    en_sync;

  // Synchronisation tracking.
  reg  [2:0]             loss_cnt;
  reg  [2:0]             gain_cnt;
  // Running parity since the previous control word, including it.
  reg  [`SSC_WORD_W-1:0] dip_acc;
  // History of the previous word for sequencing faults.
  reg                    prev_ctrl;
  reg                    prev_payload;
  // Words since the last start of packet, saturating.
  reg  [3:0]             sop_gap;
  reg                    sop_seen;
  // Training pattern progress and reporting hold.
  reg  [3:0]             train_ctrl_cnt;
  reg  [3:0]             train_data_cnt;
  reg  [4:0]             train_hold;
  reg  [4:0]             next_train_hold;
  // Discard words until a start of packet after a flush.
  reg                    discard;

  // Decoded fields of the current word.
  wire                   is_payload;
  wire [1:0]             eops;
  wire                   is_sop;
  wire [7:0]             addr;
  wire                   is_train_ctrl;
  wire                   is_train_data;
  wire                   dip_ok;
  wire                   train_done;
  wire                   sop_word;
  wire                   store_now;
  // Fault causes of the current word, before framing gating.
  wire [5:0]             cause_now;

  // ============================================================
  // DIP-4 fold of sixteen bits into four.
  function [3:0] ssc_fold4;
    input [15:0] v;
    begin
      ssc_fold4 = v[15:12] ^ v[11:8] ^ v[7:4] ^ v[3:0];
    end
  endfunction

  // ============================================================
  // Line capture and status transmit.

  // Capture both edges of the line clock into a word stream.
  ssc_ddr_capture u_capture (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .line_clk    (rx_line_clock),
    .line_bus    (rx_line_bus),
    .line_ctrl   (rx_line_ctrl_flag),
    .line_rise   (line_rise),
    .word_strobe (ws),
    .word        (w),
    .word_ctrl   (w_ctrl)
  );

  // Status clock and status pairs; framing is forced while disabled.
  ssc_status_tx u_status (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .line_rise     (line_rise),
    .div_eighth    (flow_status_clock_divider),
    .force_framing (~en_sync),
    .status_in     (flow_status_word),
    .status_clk    (rx_flow_status_clock),
    .status_bits   (rx_flow_status_bits)
  );

  // ============================================================
  // Enable resynchroniser.

  // Enable comes from the status domain; only the second stage is read.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      en_meta <= receiver_enable;
      en_sync <= en_meta;
    end
  end

  // ============================================================
  // Word decode.

  assign is_payload    = w_ctrl & w[`SSC_CW_TYPE_BIT];
  assign eops          = w[`SSC_CW_EOPS_HI:`SSC_CW_EOPS_LO];
  assign is_sop        = w[`SSC_CW_SOP_BIT];
  assign addr          = w[`SSC_CW_ADDR_HI:`SSC_CW_ADDR_LO];
  assign is_train_ctrl = w_ctrl & (w == `SSC_TRAIN_CTRL_WORD);
  assign is_train_data = ~w_ctrl & (w == `SSC_TRAIN_DATA_WORD);
  assign sop_word      = is_payload & is_sop;

  // The DIP field of the checked word counts as all ones.
  assign dip_ok = (ssc_fold4(dip_acc ^ {w[`SSC_WORD_W-1:4], `SSC_DIP_FILL})
                   == w[`SSC_CW_DIP_HI:`SSC_CW_DIP_LO]);

  // Ten training data words after at least ten training control words.
  assign train_done = ws & is_train_data & (train_ctrl_cnt == `SSC_TRAIN_REPS)
                      & (train_data_cnt == (`SSC_TRAIN_REPS - 4'h1));

  assign cause_now[`SSC_CAUSE_SOP_SPACE] = sop_word & sop_seen & (sop_gap < MIN_SOP_SPACING);
  assign cause_now[`SSC_CAUSE_EOP_NODAT] = w_ctrl & (eops != 2'h0) & prev_ctrl;
  assign cause_now[`SSC_CAUSE_PAY_NODAT] = w_ctrl & prev_payload;
  assign cause_now[`SSC_CAUSE_DIP4]      = w_ctrl & ~w[`SSC_CW_TYPE_BIT] & ~dip_ok;
  assign cause_now[`SSC_CAUSE_RSVD_CW]   = w_ctrl & ~w[`SSC_CW_TYPE_BIT] & is_sop;
  assign cause_now[`SSC_CAUSE_ADDR_NZ]   = w_ctrl & ~w[`SSC_CW_TYPE_BIT] & ~is_train_ctrl
                                           & (addr != 8'h00);

  // Words are stored only when enabled, in frame and not discarding; the SOP word ending a discard is stored too.
  assign store_now = ws & en_sync & ~receiver_out_of_sync & (~discard | (w_ctrl & sop_word));

  // ============================================================
  // Word history, parity and SOP spacing.

  // Bookkeeping follows every captured word while enabled.
  always @(posedge core_clk) begin
    if (!rst_b || !en_sync) begin
      dip_acc      <= 16'h0000;
      prev_ctrl    <= 1'b0;
      prev_payload <= 1'b0;
      sop_gap      <= 4'h0;
      sop_seen     <= 1'b0;
    end else if (ws) begin
      dip_acc      <= w_ctrl ? w : (dip_acc ^ w);
      prev_ctrl    <= w_ctrl;
      prev_payload <= is_payload;
      if (sop_word) begin
        sop_gap  <= 4'h0;
        sop_seen <= 1'b1;
      end else if (sop_gap < MIN_SOP_SPACING) begin
        sop_gap <= sop_gap + 4'h1;
      end
    end
  end

  // ============================================================
  // Training pattern decoder.

  // Any word breaking the pattern restarts it; a run of control words may be longer than ten.
  always @(posedge core_clk) begin
    if (!rst_b || !en_sync) begin
      train_ctrl_cnt <= 4'h0;
      train_data_cnt <= 4'h0;
    end else if (ws) begin
      if (is_train_ctrl) begin
        train_data_cnt <= 4'h0;
        if (train_data_cnt != 4'h0) begin
          train_ctrl_cnt <= 4'h1;
        end else if (train_ctrl_cnt != `SSC_TRAIN_REPS) begin
          train_ctrl_cnt <= train_ctrl_cnt + 4'h1;
        end
      end else if (is_train_data && train_ctrl_cnt == `SSC_TRAIN_REPS && !train_done) begin
        train_data_cnt <= train_data_cnt + 4'h1;
      end else begin
        // A finished pattern or a foreign word clears progress.
        train_ctrl_cnt <= 4'h0;
        train_data_cnt <= 4'h0;
      end
    end
  end

  // Hold counter for the training flag, measured in line words.
  always @* begin
    next_train_hold = train_hold;
    if (train_done) begin
      next_train_hold = `SSC_TRAIN_HOLD;
    end else if (ws && train_hold != 5'h00) begin
      next_train_hold = train_hold - 5'h01;
    end
  end

  // The flag is reported after decoding, since success is known only at the last word.
  always @(posedge core_clk) begin
    if (!rst_b || !en_sync) begin
      train_hold    <= 5'h00;
      training_seen <= 1'b0;
    end else begin
      train_hold    <= next_train_hold;
      training_seen <= (next_train_hold != 5'h00);
    end
  end

  // ============================================================
  // Frame synchronisation.

  // Lost after consecutive parity failures, regained by good parity or a training pattern.
  always @(posedge core_clk) begin
    if (!rst_b || !en_sync) begin
      receiver_out_of_sync <= 1'b1;
      loss_cnt             <= 3'h0;
      gain_cnt             <= 3'h0;
    end else if (train_done) begin
      receiver_out_of_sync <= 1'b0;
      loss_cnt             <= 3'h0;
      gain_cnt             <= 3'h0;
    end else if (ws && w_ctrl) begin
      if (!dip_ok) begin
        gain_cnt <= 3'h0;
        if (loss_cnt == LOSS_COUNT - 3'h1) begin
          receiver_out_of_sync <= 1'b1;
          loss_cnt             <= 3'h0;
        end else begin
          loss_cnt <= loss_cnt + 3'h1;
        end
      end else begin
        loss_cnt <= 3'h0;
        if (receiver_out_of_sync) begin
          if (gain_cnt == GAIN_COUNT - 3'h1) begin
            receiver_out_of_sync <= 1'b0;
            gain_cnt             <= 3'h0;
          end else begin
            gain_cnt <= gain_cnt + 3'h1;
          end
        end
      end
    end
  end

  // ============================================================
  // Protocol fault reporting.

  // Fault and cause form a one cycle pulse; faults are judged only while in frame.
  always @(posedge core_clk) begin
    if (!rst_b || !en_sync) begin
      receiver_protocol_fault <= 1'b0;
      receiver_fault_cause    <= 8'h00;
    end else if (ws && !receiver_out_of_sync && (cause_now != 6'h00)) begin
      receiver_protocol_fault <= 1'b1;
      receiver_fault_cause    <= {2'h0, cause_now};
    end else begin
      receiver_protocol_fault <= 1'b0;
      receiver_fault_cause    <= 8'h00;
    end
  end

  // ============================================================
  // Buffer flush and discard.

  // The flush leaves framing alone; only the store path is cleared.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      buffer_clear <= 1'b1;
      discard      <= 1'b1;
    end else begin
      buffer_clear <= ~buffer_flush_low;
      if (!buffer_flush_low) begin
        discard <= 1'b1;
      end else if (ws && sop_word && en_sync && !receiver_out_of_sync) begin
        discard <= 1'b0;
      end
    end
  end

  // ============================================================
  // Store path towards the buffer.

  // Disabling stops writes but never touches what is already stored.
  always @(posedge core_clk) begin
    if (!rst_b || !buffer_flush_low) begin
      store_valid <= 1'b0;
      store_word  <= 16'h0000;
      store_ctrl  <= 1'b0;
    end else begin
      store_valid <= store_now;
      if (store_now) begin
        store_word <= w;
        store_ctrl <= w_ctrl;
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/ssc_sink_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"

// ============================================================
// Port checker for the receive sink.
module ssc_sink_chk (
  input wire logic                    core_clk,
  input wire logic                    rst_b,
  input wire logic                    rx_line_clock,
  input wire logic                    flow_status_clock_divider,
  input wire logic                    buffer_flush_low,
  input wire logic                    receiver_enable,
  input wire logic                    rx_flow_status_clock,
  input wire logic [1:0]              rx_flow_status_bits,
  input wire logic                    receiver_out_of_sync,
  input wire logic                    receiver_protocol_fault,
  input wire logic [`SSC_CAUSE_W-1:0] receiver_fault_cause,
  input wire logic                    training_seen,
  input wire logic                    buffer_clear,
  input wire logic                    store_valid,
  input wire logic [`SSC_WORD_W-1:0]  store_word,
  input wire logic                    store_ctrl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ============================================================
  // Helper state.
  logic       lc_q;        // Line clock one edge ago.
  logic       sc_q;        // Status clock one edge ago.
  logic       div_q;       // Divider one edge ago.
  logic       armed;       // A whole status half period lies behind us.
  logic [2:0] rises;       // Line rises in this status half period.
  logic [5:0] train_words; // Words taken while the training flag is high.
  logic [3:0] en_hist;     // Recent enable samples.
  logic       discard;     // Set by a clear, ended by the first store.
  wire        rise      = rx_line_clock & ~lc_q;
  wire        word_stb  = rx_line_clock ^ lc_q;
  wire        sc_chg    = rx_flow_status_clock ^ sc_q;
  wire  [2:0] rises_now = rises + {2'h0, rise};

  // A divider change disarms the rate check, since that half period mixes both rates.
  always @(posedge core_clk) begin
    lc_q        <= rx_line_clock;
    sc_q        <= rx_flow_status_clock;
    div_q       <= flow_status_clock_divider;
    en_hist     <= {en_hist[2:0], receiver_enable};
    rises       <= sc_chg ? 3'h0 : rises_now;
    armed       <= rst_b & (div_q == flow_status_clock_divider) & (armed | sc_chg);
    train_words <= training_seen ? train_words + {5'h00, word_stb} : 6'h00;
    discard     <= !rst_b | buffer_clear | (discard & !store_valid);
  end

  // ============================================================
  // Sequences and assertions.
  sequence seq_disabled;
    !receiver_enable [*4];
  endsequence
  sequence seq_flush;
    !buffer_flush_low && !receiver_out_of_sync;
  endsequence

  AST_RESET_STATE: assert property (disable iff (1'b0)
    !rst_b |=> receiver_out_of_sync && !receiver_protocol_fault && !training_seen
      && buffer_clear && !store_valid && rx_flow_status_bits == `SSC_FRAMING_STATUS)
    else $error("state during reset is wrong");
  AST_DISABLED: assert property (seq_disabled |-> receiver_out_of_sync
    && !training_seen && !receiver_protocol_fault && !store_valid
    && rx_flow_status_bits == `SSC_FRAMING_STATUS)
    else $error("disabled sink state is wrong");
  AST_FAULT_PULSE: assert property (
    receiver_protocol_fault |=> !receiver_protocol_fault)
    else $error("fault longer than one cycle");
  AST_CAUSE_WITH_FAULT: assert property (
    receiver_protocol_fault == (receiver_fault_cause != 8'h00))
    else $error("fault and cause disagree");
  AST_CAUSE_TOP_LOW: assert property (receiver_fault_cause[7:6] == 2'h0)
    else $error("reserved cause bits set");
  AST_STATUS_RATE: assert property (sc_chg && armed |->
    rises_now == (flow_status_clock_divider ? 3'h4 : 3'h2))
    else $error("status clock rate wrong");
  AST_TRAIN_HOLD: assert property (
    $fell(training_seen) && &en_hist |-> train_words == 6'h14)
    else $error("training flag length wrong");
  AST_FLUSH: assert property (
    seq_flush |=> buffer_clear && !store_valid && !receiver_out_of_sync)
    else $error("flush handling wrong");
  AST_FIRST_STORE_SOP: assert property (store_valid && discard |->
    store_ctrl && store_word[`SSC_CW_TYPE_BIT] && store_word[`SSC_CW_SOP_BIT])
    else $error("stored before start of packet");
endmodule

bind ssc_sink_control_status ssc_sink_chk i_chk (.*);
`default_nettype wire

// ### dv/ssc_line_src.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"

// ============================================================
// Behavioural transmitting peer on the line side.
module ssc_line_src (
  input  wire logic                   core_clk,
  output var  logic                   rx_line_clock,
  output var  logic [`SSC_WORD_W-1:0] rx_line_bus,
  output var  logic                   rx_line_ctrl_flag
);
  logic [`SSC_WORD_W-1:0] acc = 16'h0000; // Last control word folded with later data.

  initial begin
    rx_line_clock     = 1'b0;
    rx_line_bus       = 16'h0000;
    rx_line_ctrl_flag = 1'b0;
  end

  // Mode 0 sends as given, 1 with good parity, 2 with parity broken on purpose.
  // Each half period lasts two core cycles; the sink accepts half periods as short as one core cycle.
  task automatic send(input logic [15:0] w, input logic c, input logic [1:0] mode);
    logic [15:0] t;
    t = acc ^ {w[15:4], `SSC_DIP_FILL};
    if (c && mode != 2'h0) begin
      w[3:0] = t[15:12] ^ t[11:8] ^ t[7:4] ^ t[3:0] ^ {3'h0, mode[1]};
    end
    @(negedge core_clk);
    rx_line_bus       = w;
    rx_line_ctrl_flag = c;
    rx_line_clock     = ~rx_line_clock;
    acc               = c ? w : acc ^ w;
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### dv/ssc_sink_control_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"

// ============================================================
// Self-checking bench for the receive sink.
module ssc_sink_control_status_tb;
  logic                    core_clk;
  logic                    rst_b;
  wire                     rx_line_clock;
  wire  [`SSC_WORD_W-1:0]  rx_line_bus;
  wire                     rx_line_ctrl_flag;
  logic                    flow_status_clock_divider;
  logic [1:0]              flow_status_word;
  logic                    buffer_flush_low;
  logic                    receiver_enable;
  wire                     rx_flow_status_clock;
  wire  [1:0]              rx_flow_status_bits;
  wire                     receiver_out_of_sync;
  wire                     receiver_protocol_fault;
  wire  [`SSC_CAUSE_W-1:0] receiver_fault_cause;
  wire                     training_seen;
  wire                     buffer_clear;
  wire                     store_valid;
  wire  [`SSC_WORD_W-1:0]  store_word;
  wire                     store_ctrl;
  integer                  miscompares = 0;
  integer                  cmp_count   = 0;
  integer                  stores      = 0;     // Words stored so far.
  integer                  sc_edges    = 0;     // Status clock changes so far.
  integer                  n;                   // Counter snapshot.
  integer                  i;
  logic                    sc_q        = 1'b0;
  logic [7:0]              seen_cause  = 8'h00; // Causes gathered since the last clear.
  // Fault table: each word follows the one before it, so the order matters.
  logic [15:0]             tw [0:6] = '{16'h0000, 16'h1000, 16'h0010, 16'h0000,
                                        16'h6000, 16'h9000, 16'h0000};
  logic [7:0]              tc [0:6] = '{8'h00, 8'h10, 8'h20, 8'h08, 8'h02, 8'h01, 8'h04};

  ssc_sink_control_status i_dut (.*);
  ssc_line_src i_src (.*);

  // ============================================================
  // Clock, monitors and shared tasks.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Counts stores and status clock changes, gathers fault causes.
  always @(posedge core_clk) begin
    sc_q <= rx_flow_status_clock;
    if (rx_flow_status_clock !== sc_q) begin
      sc_edges <= sc_edges + 1;
    end
    if (store_valid === 1'b1) begin
      stores <= stores + 1;
    end
    if (receiver_protocol_fault === 1'b1) begin
      seen_cause <= seen_cause | receiver_fault_cause;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The fault shows two edges after capture, so wait before judging it.
  task automatic send_chk(input logic [15:0] w, input logic [1:0] m, input logic [7:0] exp);
    seen_cause = 8'h00;
    i_src.send(w, 1'b1, m);
    repeat (2) @(negedge core_clk);
    check("fault cause", {8'h00, seen_cause}, {8'h00, exp});
  endtask

  task automatic finish_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole sequence takes a few hundred cycles; this is far beyond it.
  initial begin
    #100000;
    miscompares = miscompares + 1;
    finish_test;
  end

  // ============================================================
  // Test sequence.
  initial begin
    rst_b                     = 1'b0;
    flow_status_clock_divider = 1'b0;
    flow_status_word          = 2'h1;
    buffer_flush_low          = 1'b1;
    receiver_enable           = 1'b1;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    for (i = 0; i < 20; i++) begin
      i_src.send(i < 10 ? `SSC_TRAIN_CTRL_WORD : `SSC_TRAIN_DATA_WORD, i < 10, 2'h0);
    end
    repeat (2) @(negedge core_clk);
    check("out of sync", receiver_out_of_sync, 1'b0);
    check("training seen", training_seen, 1'b1);
    repeat (20) i_src.send(16'h0000, 1'b1, 2'h1);
    repeat (2) @(negedge core_clk);
    check("training seen", training_seen, 1'b0);
    n = stores;
    i_src.send(16'h1234, 1'b0, 2'h0);
    i_src.send(16'h9000, 1'b1, 2'h1);
    i_src.send(16'hABCD, 1'b0, 2'h0);
    repeat (2) @(negedge core_clk);
    check("stored words", 16'(stores - n), 16'h0002);
    check("stored word", store_word, 16'hABCD);
    for (i = 0; i < 7; i++) begin
      send_chk(tw[i], i == 3 ? 2'h2 : 2'h1, tc[i]);
    end
    repeat (4) i_src.send(16'h0000, 1'b1, 2'h2);
    repeat (2) @(negedge core_clk);
    check("out of sync", receiver_out_of_sync, 1'b1);
    repeat (4) i_src.send(16'h0000, 1'b1, 2'h1);
    repeat (2) @(negedge core_clk);
    check("out of sync", receiver_out_of_sync, 1'b0);
    buffer_flush_low = 1'b0;
    @(negedge core_clk);
    buffer_flush_low = 1'b1;
    check("buffer clear", buffer_clear, 1'b1);
    n = stores;
    i_src.send(16'h5555, 1'b0, 2'h0);
    i_src.send(16'h9000, 1'b1, 2'h1);
    repeat (2) @(negedge core_clk);
    check("stored words", 16'(stores - n), 16'h0001);
    check("stored control", store_ctrl, 1'b1);
    check("out of sync", receiver_out_of_sync, 1'b0);
    flow_status_clock_divider = 1'b1;
    flow_status_word          = 2'h2;
    repeat (40) i_src.send(16'hABCD, 1'b0, 2'h0);
    check("status bits", rx_flow_status_bits, 2'h2);
    receiver_enable = 1'b0;
    repeat (4) @(negedge core_clk);
    check("out of sync", receiver_out_of_sync, 1'b1);
    check("status bits", rx_flow_status_bits, `SSC_FRAMING_STATUS);
    n = stores;
    i = sc_edges;
    repeat (16) i_src.send(16'h1111, 1'b0, 2'h0);
    check("stored words", 16'(stores - n), 16'h0000);
    check("status clock runs", sc_edges != i, 1'b1);
    receiver_enable = 1'b1;
    rst_b           = 1'b0;
    i = sc_edges;
    repeat (16) i_src.send(16'h2222, 1'b0, 2'h0);
    check("out of sync", receiver_out_of_sync, 1'b1);
    check("training seen", training_seen, 1'b0);
    check("buffer clear", buffer_clear, 1'b1);
    check("status bits", rx_flow_status_bits, `SSC_FRAMING_STATUS);
    check("status clock runs", sc_edges != i, 1'b1);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
    finish_test;
  end
endmodule
`default_nettype wire
